// *** hdl/apc_consts.svh ***
`ifndef APC_CONSTS_SVH
`define APC_CONSTS_SVH

// ****************************************
// Result format
// ****************************************
`define APC_RES_W        10
`define APC_BYTE_W       8
`define APC_SAR_MSB      10'h200
`define APC_HI_PAD       6'h00

// ****************************************
// Configuration byte fields
// ****************************************
`define APC_ACQ_MODE_BIT 5
`define APC_CFG_RST      8'h00

// ****************************************
// Conversion timing in conversion clocks, internal divider in reference clocks
// ****************************************
`define APC_CONV_LAST    4'hC
`define APC_BIT_STEPS    4'hA
`define APC_ACQ_LAST     4'h2
`define APC_INT_DIV_LAST 4'h4

// ****************************************
// Host strobe timing in reference clocks
// ****************************************
`define APC_WR_LOW_LAST  4'h3
`define APC_WR_HOLD_LAST 4'h7
`define APC_RD_LOW_LAST  4'h7
`define APC_RD_GAP_LAST  4'h3
`define APC_EXT_HALF     4'h2
`define APC_CNT_ONE      4'h1
`define APC_CNT_ZERO     4'h0

`endif

// *** hdl/apc_pkg.sv ***
package apc_pkg;

  // ****************************************
  // Device and host states
  // ****************************************
  typedef enum logic [1:0] {
    APC_IDLE,
    APC_ACQ_INT,
    APC_ACQ_EXT,
    APC_CONV
  } apc_dev_st_t;

  typedef enum logic [2:0] {
    APC_H_IDLE,
    APC_H_WR_LOW,
    APC_H_WR_HOLD,
    APC_H_WAIT,
    APC_H_RD_LO,
    APC_H_RD_GAP,
    APC_H_RD_HI
  } apc_host_st_t;

  // ****************************************
  // Register images
  // ****************************************
  typedef struct packed {
    apc_dev_st_t st;
    logic [2:0]  cs_s;
    logic [2:0]  wr_s;
    logic [2:0]  rd_s;
    logic [2:0]  ck_s;
    logic [1:0]  up_s;
    logic [7:0]  d_s1;
    logic [7:0]  d_s2;
    logic [3:0]  div;
    logic [3:0]  cnt;
    logic [9:0]  sar;
    logic [9:0]  result;
    logic [7:0]  cfg;
    logic        done;
    logic [7:0]  dout;
    logic        dout_oe;
    logic        done_oe;
  } apc_dev_reg_t;

  typedef struct packed {
    apc_host_st_t st;
    logic [1:0]   done_s;
    logic [7:0]   d_s1;
    logic [7:0]   d_s2;
    logic [3:0]   cnt;
    logic [3:0]   ck_div;
    logic         ck;
    logic [7:0]   cfg;
    logic         cs_act;
    logic         wr_act;
    logic         rd_act;
    logic         up;
    logic         dout_oe;
    logic [7:0]   lo;
    logic [9:0]   result;
    logic         valid;
  } apc_host_reg_t;

endpackage

// *** hdl/apc_bus_if.sv ***
interface apc_bus_if;

  // ****************************************
  // Pins of the parallel bus
  // ****************************************
  logic       cs_n;
  logic       wr_n;
  logic       rd_n;
  logic       upper_part_select;
  logic       conv_clk;
  logic [7:0] data_dev;
  logic       data_dev_oe;
  logic [7:0] data_host;
  logic       data_host_oe;
  logic       done_dev_n;
  logic       done_dev_oe;
  logic [7:0] data_bus;
  logic       done_bus_n;

  // Wire levels with pull-ups when nobody drives
  assign data_bus   = data_dev_oe ? data_dev : (data_host_oe ? data_host : 8'hFF);
  assign done_bus_n = done_dev_oe ? done_dev_n : 1'b1;

  modport dev (
    input  cs_n, wr_n, rd_n, upper_part_select, conv_clk, data_bus,
    output data_dev, data_dev_oe, done_dev_n, done_dev_oe
  );

  modport host (
    input  data_bus, done_bus_n,
    output cs_n, wr_n, rd_n, upper_part_select, conv_clk, data_host, data_host_oe
  );

endinterface

// *** hdl/apc_device.sv ***
// Contract
// - Done line goes low when result ready
// - Read strobe fall with select drives result
// - Internal mode write rise starts acquire, convert
// - External mode second write rise starts conversion
// - Select high releases done and data lines
// - Host clocks pin externally, else holds it
// - Result is ten bits by successive approximation
// - Result leaves as eight plus two bits
// - Upper select picks two high or eight low
// - Done returns high on read or write
// - Conversion takes thirteen conversion clocks
// - Write during conversion aborts, restarts acquisition
`include "apc_consts.svh"

module apc_device (
  input  wire logic            REF_CLK_IN,
  input  wire logic            RESET_N_IN,
  input  wire logic            EXT_CLK_MODE_IN,
  input  wire logic            COMP_IN,
  output logic [7:0]           CONFIG_OUT,
  output logic                 TRACK_OUT,
  output logic [9:0]           DAC_CODE_OUT,
  apc_bus_if.dev               BUS
);

  // ****************************************
  // State
  // ****************************************
  apc_pkg::apc_dev_reg_t q;
  apc_pkg::apc_dev_reg_t d;
  logic                  tick;
  logic                  wr_take;
  logic                  rd_take;
  logic [9:0]            mask;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic rose(input logic [2:0] s);
    return s[1] & ~s[2];
  endfunction

  function automatic logic fell(input logic [2:0] s);
    return s[2] & ~s[1];
  endfunction

  function automatic logic [2:0] sync3(input logic [2:0] s, input logic pin);
    return {s[1:0], pin};
  endfunction

  function automatic logic strobe_take(input logic edge_seen, input logic [2:0] sel);
    return edge_seen & sel[1];
  endfunction

  function automatic logic [3:0] next_cnt(input logic [3:0] c);
    return c + `APC_CNT_ONE;
  endfunction

  function automatic logic is_acq(input apc_pkg::apc_dev_st_t st);
    return (st == apc_pkg::APC_ACQ_INT) || (st == apc_pkg::APC_ACQ_EXT);
  endfunction

  function automatic logic [7:0] read_part(input logic [9:0] res,
                                           input logic       upper);
    if (upper) begin
      return {`APC_HI_PAD, res[9:8]};
    end
    return res[7:0];
  endfunction

  function automatic logic [9:0] sar_step(input logic [9:0] sar,
                                          input logic [9:0] bit_mask,
                                          input logic       keep);
    logic [9:0] r;
    r = keep ? sar : (sar & ~bit_mask);
    r = r | (bit_mask >> 1);
    return r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;

    // ****************************************
    // Pin synchronisers, active-high images
    // ****************************************
    d.cs_s = sync3(q.cs_s, ~BUS.cs_n);
    d.wr_s = sync3(q.wr_s, ~BUS.wr_n);
    d.rd_s = sync3(q.rd_s, ~BUS.rd_n);
    d.ck_s = sync3(q.ck_s, BUS.conv_clk);
    d.up_s = {q.up_s[0], BUS.upper_part_select};
    d.d_s1 = BUS.data_bus;
    d.d_s2 = q.d_s1;

    // ****************************************
    // Conversion clock from pin or internal divider
    // ****************************************
    if (EXT_CLK_MODE_IN) begin
      tick  = fell(q.ck_s);
      d.div = `APC_CNT_ZERO;
    end else begin
      tick  = (q.div == `APC_INT_DIV_LAST);
      d.div = tick ? `APC_CNT_ZERO : next_cnt(q.div);
    end

    wr_take = strobe_take(fell(q.wr_s), q.cs_s);
    rd_take = strobe_take(rose(q.rd_s), q.cs_s);
    mask    = `APC_SAR_MSB >> q.cnt;

    // ****************************************
    // Done clears first so a completion in the same cycle wins
    // ****************************************
    if (rd_take || wr_take) begin
      d.done = 1'b0;
    end

    // ****************************************
    // Acquisition and conversion sequence
    // ****************************************
    case (q.st)
      apc_pkg::APC_IDLE: begin
        d.cnt = `APC_CNT_ZERO;
      end
      apc_pkg::APC_ACQ_INT: begin
        if (tick) begin
          if (q.cnt == `APC_ACQ_LAST) begin
            d.st  = apc_pkg::APC_CONV;
            d.cnt = `APC_CNT_ZERO;
            d.sar = `APC_SAR_MSB;
          end else begin
            d.cnt = q.cnt + `APC_CNT_ONE;
          end
        end
      end
      apc_pkg::APC_ACQ_EXT: begin
        d.cnt = `APC_CNT_ZERO;
      end
      apc_pkg::APC_CONV: begin
        if (tick) begin
          if (q.cnt < `APC_BIT_STEPS) begin
            d.sar = sar_step(q.sar, mask, COMP_IN);
          end
          if (q.cnt == `APC_CONV_LAST) begin
            d.result = q.sar;
            d.done   = 1'b1;
            d.st     = apc_pkg::APC_IDLE;
            d.cnt    = `APC_CNT_ZERO;
          end else begin
            d.cnt = q.cnt + `APC_CNT_ONE;
          end
        end
      end
      default: begin
        d.st = apc_pkg::APC_IDLE;
      end
    endcase

    // ****************************************
    // Configuration write, aborting any conversion
    // ****************************************
    if (wr_take) begin
      d.cfg = q.d_s2;
      d.cnt = `APC_CNT_ZERO;
      if (q.d_s2[`APC_ACQ_MODE_BIT]) begin
        d.st = apc_pkg::APC_ACQ_EXT;
      end else if (q.st == apc_pkg::APC_ACQ_EXT) begin
        d.st  = apc_pkg::APC_CONV;
        d.sar = `APC_SAR_MSB;
      end else begin
        d.st = apc_pkg::APC_ACQ_INT;
      end
    end

    // ****************************************
    // Read path
    // ****************************************
    d.dout    = read_part(q.result, q.up_s[1]);
    d.dout_oe = q.cs_s[1] & q.rd_s[1];
    d.done_oe = q.cs_s[1];
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign BUS.data_dev    = q.dout;
  assign BUS.data_dev_oe = q.dout_oe;
  assign BUS.done_dev_n  = ~q.done;
  assign BUS.done_dev_oe = q.done_oe;
  assign CONFIG_OUT      = q.cfg;
  assign DAC_CODE_OUT    = q.sar;
  assign TRACK_OUT       = is_acq(q.st);

endmodule

// *** hdl/apc_host.sv ***
`include "apc_consts.svh"

module apc_host (
  input  wire logic            REF_CLK_IN,
  input  wire logic            RESET_N_IN,
  input  wire logic            EXT_CLK_MODE_IN,
  input  wire logic            START_IN,
  input  wire logic [7:0]      CONFIG_IN,
  output logic                 BUSY_OUT,
  output logic [9:0]           RESULT_OUT,
  output logic                 RESULT_VALID_OUT,
  apc_bus_if.host              BUS
);

  // ****************************************
  // State
  // ****************************************
  apc_pkg::apc_host_reg_t q;
  apc_pkg::apc_host_reg_t d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d       = q;
    d.valid = 1'b0;

    // Synchronisers for pins driven by the device
    d.done_s = {q.done_s[0], BUS.done_bus_n};
    d.d_s1   = BUS.data_bus;
    d.d_s2   = q.d_s1;

    // Free-running conversion clock, or held low
    if (EXT_CLK_MODE_IN) begin
      if (q.ck_div == `APC_EXT_HALF) begin
        d.ck_div = `APC_CNT_ZERO;
        d.ck     = ~q.ck;
      end else begin
        d.ck_div = q.ck_div + `APC_CNT_ONE;
      end
    end else begin
      d.ck_div = `APC_CNT_ZERO;
      d.ck     = 1'b0;
    end

    case (q.st)
      apc_pkg::APC_H_IDLE: begin
        d.cs_act  = 1'b0;
        d.dout_oe = 1'b0;
        if (START_IN) begin
          d.cfg     = CONFIG_IN;
          d.cs_act  = 1'b1;
          d.wr_act  = 1'b1;
          d.dout_oe = 1'b1;
          d.cnt     = `APC_CNT_ZERO;
          d.st      = apc_pkg::APC_H_WR_LOW;
        end
      end
      apc_pkg::APC_H_WR_LOW: begin
        d.cnt = q.cnt + `APC_CNT_ONE;
        if (q.cnt == `APC_WR_LOW_LAST) begin
          d.wr_act = 1'b0;
          d.cnt    = `APC_CNT_ZERO;
          d.st     = apc_pkg::APC_H_WR_HOLD;
        end
      end
      apc_pkg::APC_H_WR_HOLD: begin
        d.cnt = q.cnt + `APC_CNT_ONE;
        if (q.cnt == `APC_WR_HOLD_LAST) begin
          d.dout_oe = 1'b0;
          d.cnt     = `APC_CNT_ZERO;
          if (q.cfg[`APC_ACQ_MODE_BIT]) begin
            d.cs_act = 1'b0;
            d.st     = apc_pkg::APC_H_IDLE;
          end else begin
            d.st = apc_pkg::APC_H_WAIT;
          end
        end
      end
      apc_pkg::APC_H_WAIT: begin
        d.up = 1'b0;
        if (!q.done_s[1]) begin
          d.rd_act = 1'b1;
          d.st     = apc_pkg::APC_H_RD_LO;
        end
      end
      apc_pkg::APC_H_RD_LO: begin
        d.cnt = q.cnt + `APC_CNT_ONE;
        if (q.cnt == `APC_RD_LOW_LAST) begin
          d.lo     = q.d_s2;
          d.rd_act = 1'b0;
          d.up     = 1'b1;
          d.cnt    = `APC_CNT_ZERO;
          d.st     = apc_pkg::APC_H_RD_GAP;
        end
      end
      apc_pkg::APC_H_RD_GAP: begin
        d.cnt = q.cnt + `APC_CNT_ONE;
        if (q.cnt == `APC_RD_GAP_LAST) begin
          d.rd_act = 1'b1;
          d.cnt    = `APC_CNT_ZERO;
          d.st     = apc_pkg::APC_H_RD_HI;
        end
      end
      apc_pkg::APC_H_RD_HI: begin
        d.cnt = q.cnt + `APC_CNT_ONE;
        if (q.cnt == `APC_RD_LOW_LAST) begin
          d.result = {q.d_s2[1:0], q.lo};
          d.valid  = 1'b1;
          d.rd_act = 1'b0;
          d.up     = 1'b0;
          d.cs_act = 1'b0;
          d.cnt    = `APC_CNT_ZERO;
          d.st     = apc_pkg::APC_H_IDLE;
        end
      end
      default: begin
        d.st = apc_pkg::APC_H_IDLE;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign BUS.cs_n              = ~q.cs_act;
  assign BUS.wr_n              = ~q.wr_act;
  assign BUS.rd_n              = ~q.rd_act;
  assign BUS.upper_part_select = q.up;
  assign BUS.conv_clk          = q.ck;
  assign BUS.data_host         = q.cfg;
  assign BUS.data_host_oe      = q.dout_oe;
  assign BUSY_OUT              = (q.st != apc_pkg::APC_H_IDLE);
  assign RESULT_OUT            = q.result;
  assign RESULT_VALID_OUT      = q.valid;

endmodule

// *** bench/apc_bus_props.sv ***
module apc_bus_props (
  input wire logic       REF_CLK_IN,
  input wire logic       RESET_N_IN,
  input wire logic       cs_n,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic       upper_part_select,
  input wire logic [7:0] data_dev,
  input wire logic       data_dev_oe,
  input wire logic       done_dev_n,
  input wire logic       done_dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  // ****************************************
  // Strobe edges seen with select low, and upper select held while data is driven
  // ****************************************
  sequence s_rd_edge;
    $fell(rd_n) && !cs_n;
  endsequence

  sequence s_wr_edge;
    $rose(wr_n) && !cs_n;
  endsequence

  sequence s_upper_held;
    upper_part_select[*4] ##0 data_dev_oe;
  endsequence

  // ****************************************
  // Checks
  // ****************************************
  a_done_holds: assert property (!done_dev_n && rd_n && wr_n && $past(wr_n, 3)
    |=> !done_dev_n)
    else $error("done line released without a strobe");
  a_read_drive: assert property (s_rd_edge |-> ##3 data_dev_oe)
    else $error("data not driven after read strobe");
  a_oe_cause: assert property (data_dev_oe |-> !$past(cs_n, 3) && !$past(rd_n, 3))
    else $error("data driven without a read");
  a_select_release: assert property (cs_n[*4] |-> !data_dev_oe && !done_dev_oe)
    else $error("outputs driven while deselected");
  a_done_oe: assert property ((!cs_n)[*4] |-> done_dev_oe)
    else $error("done line not driven while selected");
  a_upper_pad: assert property (s_upper_held |-> data_dev[7:2] == 6'h00)
    else $error("upper part not padded with zeros");
  a_read_clears: assert property (s_rd_edge |-> ##3 done_dev_n)
    else $error("done not cleared by read");
  a_write_clears: assert property (s_wr_edge |-> ##3 done_dev_n)
    else $error("done not cleared by write");
  a_data_stable: assert property ($stable(upper_part_select)[*4] ##0 data_dev_oe[*2]
    |-> $stable(data_dev))
    else $error("read data changed within one part");
endmodule

// *** bench/test_adc_parallel_host_control.sv ***
module test_adc_parallel_host_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic       ref_clk;
  logic       reset_n;
  logic       ext_mode;
  logic       comp;
  logic       start;
  logic [7:0] config_in;
  logic [7:0] config_out;
  logic       track;
  logic       busy;
  logic       res_valid;
  logic [9:0] dac_code;
  logic [9:0] result;
  logic [9:0] vin;
  int         miscompares;
  int         samples_checked;
  logic [7:0] cfg_tab [6] = '{8'h00, 8'h01, 8'h00, 8'h11, 8'h20, 8'h00};
  logic [9:0] vin_tab [6] = '{10'h2A5, 10'h3FF, 10'h000, 10'h155, 10'h000, 10'h0AA};
  logic       ext_tab [6] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
  logic       tmd_tab [6] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};

  apc_bus_if apc_bus_if_i();
  apc_device apc_device_i (.REF_CLK_IN(ref_clk), .RESET_N_IN(reset_n), .EXT_CLK_MODE_IN(ext_mode),
    .COMP_IN(comp), .CONFIG_OUT(config_out), .TRACK_OUT(track), .DAC_CODE_OUT(dac_code),
    .BUS(apc_bus_if_i));
  apc_host apc_host_i (.REF_CLK_IN(ref_clk), .RESET_N_IN(reset_n), .EXT_CLK_MODE_IN(ext_mode),
    .START_IN(start), .CONFIG_IN(config_in), .BUSY_OUT(busy), .RESULT_OUT(result),
    .RESULT_VALID_OUT(res_valid), .BUS(apc_bus_if_i));
  apc_bus_props apc_bus_props_i (.REF_CLK_IN(ref_clk), .RESET_N_IN(reset_n),
    .cs_n(apc_bus_if_i.cs_n), .wr_n(apc_bus_if_i.wr_n), .rd_n(apc_bus_if_i.rd_n),
    .upper_part_select(apc_bus_if_i.upper_part_select), .data_dev(apc_bus_if_i.data_dev),
    .data_dev_oe(apc_bus_if_i.data_dev_oe), .done_dev_n(apc_bus_if_i.done_dev_n),
    .done_dev_oe(apc_bus_if_i.done_dev_oe));

  // Comparator: keep trial bit when input at or above code
  assign comp = (vin >= dac_code);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Compares %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One host sequence: write, then read both parts unless start only
  task automatic run(input logic [7:0] cfg, input logic [9:0] v, input logic ext,
                     input logic timed);
    int   n;
    int   t0;
    int   t1;
    logic got;
    logic seen_done;
    logic trk_q;
    n = 0;
    t0 = 0;
    t1 = 0;
    got = 1'h0;
    seen_done = 1'h0;
    trk_q = 1'h0;
    vin = v;
    ext_mode = ext;
    @(posedge ref_clk);
    #1;
    start = 1'h1;
    config_in = cfg;
    @(posedge ref_clk);
    #1;
    start = 1'h0;
    while (busy !== 1'h0 && n < 3000) begin
      if (trk_q === 1'h1 && track === 1'h0) t0 = n;
      if (apc_bus_if_i.done_bus_n === 1'h0 && !seen_done) begin
        seen_done = 1'h1;
        t1 = n;
      end
      if (res_valid === 1'h1) got = 1'h1;
      trk_q = track;
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (res_valid === 1'h1) got = 1'h1;
    if (n >= 3000) begin
      miscompares++;
      results();
    end
    check({2'h0, config_out}, {2'h0, cfg});
    if (cfg[5]) begin
      check({9'h000, track}, 10'h001);
    end else begin
      check({9'h000, got}, 10'h001);
      check({9'h000, seen_done}, 10'h001);
      check(result, v);
      check({9'h000, apc_bus_if_i.done_dev_n}, 10'h001);
      if (timed) check(10'(t1 - t0), ext ? 10'h04E : 10'h041);
    end
    repeat (4) @(posedge ref_clk);
    #1;
    check({8'h00, apc_bus_if_i.data_dev_oe, apc_bus_if_i.done_dev_oe}, 10'h000);
  endtask

  // ****************************************
  // Clock and main sequence
  // ****************************************
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    reset_n = 1'h0;
    ext_mode = 1'h0;
    start = 1'h0;
    config_in = 8'h00;
    vin = 10'h000;
    miscompares = 0;
    samples_checked = 0;
    repeat (5) @(posedge ref_clk);
    #1;
    reset_n = 1'h1;
    for (int i = 0; i < 6; i++) begin
      run(cfg_tab[i], vin_tab[i], ext_tab[i], tmd_tab[i]);
    end
    results();
  end
endmodule
